// ---- raq_pkg.sv ----
// Purpose: Shared constants and types for the alarm qualifier and control block.
// Assumes: 32-bit AHB-Lite register access, one word per register index.
// Notes: Byte address of a register is four times its index.
package raq_pkg;
    localparam logic [7:0] IDX_ALARM_FLAGS = 8'h0c;
    localparam logic [7:0] IDX_MONTH_MATCH = 8'h0d;
    localparam logic [7:0] IDX_CONTROL = 8'h10;
    localparam logic [7:0] IDX_WEEKDAY_MATCH = 8'h14;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h20;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h21;

    localparam int CTRL_BLOCK_EN_BIT = 0;
    localparam int CTRL_SOFT_RESET_BIT = 1;
    localparam int CTRL_WAKE_ROUTE_BIT = 2;
    localparam int CTRL_ALARM_EN_BIT = 3;
    localparam int FLAG_ALARM_BIT = 5;
    localparam int IRQ_ALARM_BIT = 0;

    localparam logic [3:0] CTRL_RESET = 4'h0;
    localparam logic [5:0] MONTH_MATCH_RESET = 6'h00;
    localparam logic [7:0] WEEKDAY_MATCH_RESET = 8'hff;
    localparam logic [7:0] WEEKDAY_DONT_CARE = 8'hff;
    localparam logic [1:0] WEEKDAY_DC_TOP = 2'h3;
    localparam logic [7:0] WEEKDAY_MIN = 8'h01;
    localparam logic [7:0] WEEKDAY_MAX = 8'h07;

    localparam int CLK_PERIOD_PS = 4000;
    localparam int SOFT_RESET_NS = 8;
    localparam int SOFT_RESET_CYCLES = (SOFT_RESET_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    typedef struct packed {
        logic alarm_en;
        logic wake_route_on;
        logic soft_reset;
        logic block_en;
    } raq_ctrl_t;

    typedef struct packed {
        logic base_match;
        logic [7:0] month;
        logic [7:0] weekday;
    } raq_time_t;
endpackage

// ---- raq_properties.sv ----
// Purpose: Port-level checks of the alarm qualifier and control block.
// Assumes: One clock domain, hresetn active low.
// Notes: Bound to raq_top after the checker.
`timescale 1ns/10ps
module raq_properties
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire raq_pkg::raq_time_t now,
    input wire logic block_running,
    input wire logic rtc_rst_n,
    input wire logic alarm_event,
    input wire logic wake_input_circuit,
    input wire logic irq
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence soft_s;
        $fell(rtc_rst_n);
    endsequence
    sequence held_s;
        !rtc_rst_n [*2];
    endsequence
    a_event_cause: assert property (alarm_event |-> $past(now.base_match))
        else $error("alarm event without base match");
    a_wake_cause: assert property (wake_input_circuit |-> $past(alarm_event))
        else $error("wake pulse without alarm event");
    a_run_gate: assert property (alarm_event |-> block_running)
        else $error("alarm event while block stopped");
    a_reset_gate: assert property (alarm_event |-> rtc_rst_n)
        else $error("alarm event during soft reset");
    a_soft_len: assert property (soft_s |-> ##[1:4] rtc_rst_n)
        else $error("soft reset did not end");
    a_soft_stops: assert property (soft_s |-> ##[0:2] !block_running)
        else $error("block kept running in soft reset");
    a_irq_cleared: assert property (held_s |=> !irq)
        else $error("interrupt survived soft reset");
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus stalled or errored");
endmodule // raq_properties
bind raq_top raq_properties u_props (.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout),
    .hresp(hresp), .now(now), .block_running(block_running), .rtc_rst_n(rtc_rst_n),
    .alarm_event(alarm_event), .wake_input_circuit(wake_input_circuit), .irq(irq));

// ---- raq_qualifier.sv ----
// Purpose: Qualifies the base alarm match with month and day-of-week fields.
// Assumes: All inputs come from logic on hclk.
// Notes: The event output is registered; it follows the qualified base match one cycle later.
`timescale 1ns/10ps
module raq_qualifier
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic soft_rst,
    input wire logic enable,
    input wire raq_pkg::raq_time_t now,
    input wire logic [5:0] month_match_value,
    input wire logic [7:0] weekday_match_value,
    output logic alarm_event
);
    logic month_ok;
    logic weekday_ok;
    logic weekday_active;

    assign month_ok = (month_match_value == 6'h00) || ({2'h0, month_match_value} == now.month);
    assign weekday_active = (weekday_match_value >= raq_pkg::WEEKDAY_MIN)
        && (weekday_match_value <= raq_pkg::WEEKDAY_MAX);
    assign weekday_ok = !weekday_active || (weekday_match_value == now.weekday);

    // One evaluation per cycle of all fields together.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            alarm_event <= 1'b0;
        else if (soft_rst)
            alarm_event <= 1'b0;
        else
            alarm_event <= enable && now.base_match && month_ok && weekday_ok;
    end
endmodule // raq_qualifier

// ---- raq_top.sv ----
// Purpose: Control register, alarm qualifiers, alarm flag and interrupt for the clock block.
// Assumes: hresetn is the battery-domain reset; soft reset makes the clock-domain reset.
// Notes: Zero wait state AHB-Lite slave; read data is registered in the address phase.
//
// Operation
// - Non-zero month match field gates alarm on equality with current month.
// - Month match field of zero makes month a don't-care.
// - Alarm detection runs only while control bit 3 is one.
// - Control bit 2 forwards alarm events to the wake circuit.
// - Writing one to control bit 1 asserts the clock-domain reset.
// - Soft reset restores all registers except control.
// - Soft reset bit self-clears; control resets only on battery reset.
// - Block logic, including alarm evaluation, runs only while control bit 0 is one.
// - Weekday match values one to seven gate alarm on weekday equality.
// - Written weekday values with top two bits set mean don't-care.
// - After a don't-care write the weekday field reads all ones.
// - Alarm flag bit 5 sets on each alarm, clears on read.
`timescale 1ns/10ps
module raq_top
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire raq_pkg::raq_time_t now,
    output logic block_running,
    output logic rtc_rst_n,
    output logic alarm_event,
    output logic wake_input_circuit,
    output logic irq
);
    ////////////////////////////////////////////////////////////////////////////////
    // Declarations.
    raq_pkg::raq_ctrl_t ctrl;
    logic [5:0] month_match;
    logic [7:0] weekday_match_value;
    logic [7:0] alarm_flags;
    logic irq_status;
    logic irq_mask;
    logic soft_rst;
    logic [3:0] soft_cnt;
    logic dp_write;
    logic [7:0] dp_index;
    logic ap_valid;
    logic [7:0] ap_index;
    logic wr_month;
    logic wr_ctrl;
    logic wr_weekday;
    logic wr_irq_status;
    logic wr_irq_mask;
    logic rd_flags;
    logic [31:0] next_hrdata;
    logic qual_event;

    if (raq_pkg::SOFT_RESET_CYCLES < 1 || raq_pkg::SOFT_RESET_CYCLES > 15)
    begin : g_bad_soft_len
        $error("Soft reset length does not fit its counter.");
    end

    function automatic logic idx_hit(input logic [7:0] idx, input logic [7:0] want);
        idx_hit = (idx == want);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Bus address phase.
    assign ap_valid = hsel && htrans[1] && hready;
    assign ap_index = haddr[9:2];
    assign wr_month = dp_write && idx_hit(dp_index, raq_pkg::IDX_MONTH_MATCH);
    assign wr_ctrl = dp_write && idx_hit(dp_index, raq_pkg::IDX_CONTROL);
    assign wr_weekday = dp_write && idx_hit(dp_index, raq_pkg::IDX_WEEKDAY_MATCH);
    assign wr_irq_status = dp_write && idx_hit(dp_index, raq_pkg::IDX_IRQ_STATUS);
    assign wr_irq_mask = dp_write && idx_hit(dp_index, raq_pkg::IDX_IRQ_MASK);
    assign rd_flags = ap_valid && !hwrite && idx_hit(ap_index, raq_pkg::IDX_ALARM_FLAGS);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dp_write <= 1'b0;
            dp_index <= 8'h00;
        end
        else
        begin
            dp_write <= ap_valid && hwrite;
            dp_index <= ap_index;
        end
    end

    always_comb
    begin
        next_hrdata = 32'h0000_0000;
        if (idx_hit(ap_index, raq_pkg::IDX_ALARM_FLAGS))
            next_hrdata = {24'h0, alarm_flags};
        else if (idx_hit(ap_index, raq_pkg::IDX_MONTH_MATCH))
            next_hrdata = {26'h0, month_match};
        else if (idx_hit(ap_index, raq_pkg::IDX_CONTROL))
            next_hrdata = {28'h0, ctrl};
        else if (idx_hit(ap_index, raq_pkg::IDX_WEEKDAY_MATCH))
            next_hrdata = {24'h0, weekday_match_value};
        else if (idx_hit(ap_index, raq_pkg::IDX_IRQ_STATUS))
            next_hrdata = {31'h0, irq_status};
        else if (idx_hit(ap_index, raq_pkg::IDX_IRQ_MASK))
            next_hrdata = {31'h0, irq_mask};
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (ap_valid && !hwrite)
                hrdata <= next_hrdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Control register, reset only by the battery-domain reset.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            ctrl <= raq_pkg::CTRL_RESET;
        else if (wr_ctrl)
            ctrl <= hwdata[3:0];
        else if (ctrl.soft_reset && soft_cnt == 4'h1)
            ctrl.soft_reset <= 1'b0;
    end

    // Soft reset length counter.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            soft_cnt <= 4'h0;
        else if (wr_ctrl && hwdata[raq_pkg::CTRL_SOFT_RESET_BIT])
            soft_cnt <= 4'(raq_pkg::SOFT_RESET_CYCLES);
        else if (soft_cnt != 4'h0)
            soft_cnt <= soft_cnt - 4'h1;
    end

    assign soft_rst = ctrl.soft_reset;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rtc_rst_n <= 1'b0;
            block_running <= 1'b0;
        end
        else
        begin
            rtc_rst_n <= !soft_rst;
            block_running <= ctrl.block_en && !soft_rst;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Alarm match registers, returned to their reset values by either reset.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            month_match <= raq_pkg::MONTH_MATCH_RESET;
        else if (soft_rst)
            month_match <= raq_pkg::MONTH_MATCH_RESET;
        else if (wr_month)
            month_match <= hwdata[5:0];
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            weekday_match_value <= raq_pkg::WEEKDAY_MATCH_RESET;
        else if (soft_rst)
            weekday_match_value <= raq_pkg::WEEKDAY_MATCH_RESET;
        else if (wr_weekday && hwdata[7:6] == raq_pkg::WEEKDAY_DC_TOP)
            weekday_match_value <= raq_pkg::WEEKDAY_DONT_CARE;
        else if (wr_weekday)
            weekday_match_value <= hwdata[7:0];
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Alarm qualification.
    raq_qualifier u_qual
    (
        .hclk(hclk),
        .hresetn(hresetn),
        .soft_rst(soft_rst),
        .enable(ctrl.block_en && ctrl.alarm_en),
        .now(now),
        .month_match_value(month_match),
        .weekday_match_value(weekday_match_value),
        .alarm_event(qual_event)
    );

    assign alarm_event = qual_event;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            wake_input_circuit <= 1'b0;
        else if (soft_rst)
            wake_input_circuit <= 1'b0;
        else
            wake_input_circuit <= qual_event && ctrl.wake_route_on;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Alarm flag, cleared by reading; a new event in the same cycle wins.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            alarm_flags <= 8'h00;
        else if (soft_rst)
            alarm_flags <= 8'h00;
        else if (qual_event)
            alarm_flags[raq_pkg::FLAG_ALARM_BIT] <= 1'b1;
        else if (rd_flags)
            alarm_flags <= 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupt status, mask and output.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            irq_status <= 1'b0;
        else if (soft_rst)
            irq_status <= 1'b0;
        else if (qual_event)
            irq_status <= 1'b1;
        else if (wr_irq_status && hwdata[raq_pkg::IRQ_ALARM_BIT])
            irq_status <= 1'b0;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            irq_mask <= 1'b0;
        else if (soft_rst)
            irq_mask <= 1'b0;
        else if (wr_irq_mask)
            irq_mask <= hwdata[raq_pkg::IRQ_ALARM_BIT];
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            irq <= 1'b0;
        else
            irq <= irq_status && irq_mask;
    end
endmodule // raq_top

// ---- test_rtc_alarm_qualifier_control.sv ----
// Purpose: Self-checking bench for the alarm qualifier and control block.
// Assumes: Zero wait state slave, byte address is four times the index.
// Notes: Reads and alarm outcomes are queued and checked by the monitor.
`timescale 1ns/10ps
module test_rtc_alarm_qualifier_control;
    logic hclk = 0;
    logic hresetn = 0;
    logic hsel = 0;
    logic [31:0] haddr = '0;
    logic [1:0] htrans = '0;
    logic hwrite = 0;
    logic [31:0] hwdata = '0;
    logic [31:0] hrdata;
    logic hreadyout, hresp, block_running, rtc_rst_n, alarm_event, wake, irq;
    raq_pkg::raq_time_t now = '0;
    int miscompares = 0;
    int checks = 0;
    logic [31:0] rd_q[$];
    logic [1:0] ev_q[$];
    logic [31:0] seed = 32'h9b76;
    logic rd_ph = 0;
    logic bm1 = 0;
    logic bm2 = 0;
    logic [1:0] cur = '0;
    always #2 hclk = ~hclk;
    raq_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .now(now), .block_running(block_running),
        .rtc_rst_n(rtc_rst_n), .alarm_event(alarm_event), .wake_input_circuit(wake), .irq(irq));
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic stop_test();
        if (miscompares == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic bus(input logic [31:0] a, input logic wr, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        if (!wr)
            rd_q.push_back(d);
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask
    task automatic pulse(input logic [7:0] m, input logic [7:0] w, input logic [1:0] e);
        @(posedge hclk);
        now <= {1'b1, m, w};
        ev_q.push_back(e);
        @(posedge hclk);
        now.base_match <= 1'b0;
        repeat (4) @(posedge hclk);
    endtask
    task automatic irq_is(input logic e);
        repeat (2) @(posedge hclk);
        #1;
        chk("irq", {31'h0, irq}, {31'h0, e});
    endtask
    ////////////////////////////////////////////////////////////////////////
    always @(posedge hclk)
    begin
        rd_ph <= hsel && htrans[1] && !hwrite && hreadyout;
        bm1 <= now.base_match;
        bm2 <= bm1;
        if (rd_ph)
            chk("hresp", {31'h0, hresp}, 32'h0);
        if (rd_ph && rd_q.size() > 0)
            chk("hrdata", hrdata, rd_q.pop_front());
        if (bm1 && ev_q.size() > 0)
        begin
            cur = ev_q.pop_front();
            chk("alarm_event", {31'h0, alarm_event}, {31'h0, cur[1]});
        end
        if (bm2)
            chk("wake", {31'h0, wake}, {31'h0, cur[0]});
    end
    initial
    begin
        #40000;
        miscompares++;
        stop_test();
    end
    initial
    begin
        logic [7:0] m;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        bus(32'h34, 0, 32'h0);
        bus(32'h40, 0, 32'h0);
        bus(32'h50, 0, 32'hff);
        bus(32'hfc, 0, 32'h0);
        seed = lfsr(seed);
        bus(32'h50, 1, {24'h0, 2'h3, seed[5:0]});
        bus(32'h50, 0, 32'hff);
        seed = lfsr(seed);
        m = {4'h0, seed[3:0] | 4'h1};
        pulse(m, 8'h2, 2'b00);
        bus(32'h40, 1, 32'h1);
        pulse(m, 8'h2, 2'b00);
        bus(32'h40, 1, 32'h9);
        pulse(m, 8'h2, 2'b10);
        bus(32'h40, 1, 32'hd);
        pulse(m, 8'h2, 2'b11);
        bus(32'h30, 0, 32'h20);
        bus(32'h30, 0, 32'h0);
        bus(32'h34, 1, {24'h0, m});
        pulse(m, 8'h2, 2'b11);
        pulse(m ^ 8'h10, 8'h2, 2'b00);
        bus(32'h50, 1, 32'h5);
        for (int d = 1; d <= 7; d++)
            pulse(m, d[7:0], {2{d == 5}});
        bus(32'h84, 1, 32'h1);
        pulse(m, 8'h5, 2'b11);
        irq_is(1'b1);
        bus(32'h84, 1, 32'h0);
        irq_is(1'b0);
        bus(32'h84, 1, 32'h1);
        irq_is(1'b1);
        bus(32'h80, 1, 32'h1);
        irq_is(1'b0);
        bus(32'h40, 1, 32'hb);
        @(posedge hclk);
        #1;
        chk("rtc_rst_n", {31'h0, rtc_rst_n}, 32'h0);
        chk("block_running", {31'h0, block_running}, 32'h0);
        repeat (3) @(posedge hclk);
        #1;
        chk("rtc_rst_n", {31'h0, rtc_rst_n}, 32'h1);
        chk("block_running", {31'h0, block_running}, 32'h1);
        bus(32'h40, 0, 32'h9);
        bus(32'h34, 0, 32'h0);
        bus(32'h50, 0, 32'hff);
        pulse(m ^ 8'h10, 8'h3, 2'b10);
        hresetn <= 1'b0;
        @(posedge hclk);
        hresetn <= 1'b1;
        bus(32'h40, 0, 32'h0);
        stop_test();
    end
endmodule // test_rtc_alarm_qualifier_control
